// *** logic/jtdr_top.v ***
// jtdr_top.v: test-port tap, identification and domain-reset registers, service bus decode.
// assumes: tck/tms/tdi come from an external tester, far slower than mclk_i (tck 400 ns).
`timescale 1ns/100ps
`include "jtdr_consts.vh"

module jtdr_top #(
	parameter       NPINS   = 8,
	parameter [3:0] ID_REV  = 4'h0,    // arbitrary value
	parameter [15:0] ID_PROD = 16'h1234, // arbitrary value
	parameter [10:0] ID_MAKER = 11'h2a5  // arbitrary value
) (
	input  wire                    mclk_i,
	input  wire                    rst_n_i,
	input  wire                    tck_i,
	input  wire                    tms_i,
	input  wire                    tdi_i,
	output reg                     tdo_o,
	output reg                     tdo_oe_o,
	input  wire [NPINS-1:0]        pin_in_i,
	input  wire [NPINS-1:0]        core_out_i,
	input  wire [NPINS-1:0]        core_oe_i,
	output wire [NPINS-1:0]        pin_out_o,
	output wire [NPINS-1:0]        pin_oe_o,
	output wire [NPINS-1:0]        core_in_o,
	output reg                     core_rst_hold_o,
	output reg                     bus_rst_hold_o,
	output reg                     debug_rst_hold_o,
	input  wire                    sab_req_i,
	input  wire [`JTDR_SAB_AW-1:0] sab_addr_i,
	output reg                     sab_sel_debug_o,
	output reg                     sab_sel_sysbus_o,
	output reg                     sab_sel_msu_o,
	output reg                     sab_unmapped_o,
	output reg  [31:0]             sab_local_addr_o
);

	// tap states
	localparam [3:0] ST_TLR   = 4'h0;
	localparam [3:0] ST_RTI   = 4'h1;
	localparam [3:0] ST_SELDR = 4'h2;
	localparam [3:0] ST_CAPDR = 4'h3;
	localparam [3:0] ST_SHDR  = 4'h4;
	localparam [3:0] ST_EX1DR = 4'h5;
	localparam [3:0] ST_PSDR  = 4'h6;
	localparam [3:0] ST_EX2DR = 4'h7;
	localparam [3:0] ST_UPDR  = 4'h8;
	localparam [3:0] ST_SELIR = 4'h9;
	localparam [3:0] ST_CAPIR = 4'ha;
	localparam [3:0] ST_SHIR  = 4'hb;
	localparam [3:0] ST_EX1IR = 4'hc;
	localparam [3:0] ST_PSIR  = 4'hd;
	localparam [3:0] ST_EX2IR = 4'he;
	localparam [3:0] ST_UPIR  = 4'hf;

	// ==========================================================
	// pin synchronisers and tck edge detection
	reg tck_m, tck_s, tck_d;
	reg tms_m, tms_s;
	reg tdi_m, tdi_s;

	// two flops per pin; edges only look at the second stage onward
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			tck_m <= 1'b0;
			tck_s <= 1'b0;
			tck_d <= 1'b0;
			tms_m <= 1'b1;
			tms_s <= 1'b1;
			tdi_m <= 1'b1;
			tdi_s <= 1'b1;
		end else begin
			tck_m <= tck_i;
			tck_s <= tck_m;
			tck_d <= tck_s;
			tms_m <= tms_i;
			tms_s <= tms_m;
			tdi_m <= tdi_i;
			tdi_s <= tdi_m;
		end
	end

	wire tck_rise = tck_s & ~tck_d;
	wire tck_fall = ~tck_s & tck_d;

	// ==========================================================
	// tap controller
	reg [3:0] state;
	reg [3:0] next_state;

	// standard sixteen-state walk driven by tms
	always @* begin
		case (state)
			ST_TLR:   next_state = tms_s ? ST_TLR   : ST_RTI;
			ST_RTI:   next_state = tms_s ? ST_SELDR : ST_RTI;
			ST_SELDR: next_state = tms_s ? ST_SELIR : ST_CAPDR;
			ST_CAPDR: next_state = tms_s ? ST_EX1DR : ST_SHDR;
			ST_SHDR:  next_state = tms_s ? ST_EX1DR : ST_SHDR;
			ST_EX1DR: next_state = tms_s ? ST_UPDR  : ST_PSDR;
			ST_PSDR:  next_state = tms_s ? ST_EX2DR : ST_PSDR;
			ST_EX2DR: next_state = tms_s ? ST_UPDR  : ST_SHDR;
			ST_UPDR:  next_state = tms_s ? ST_SELDR : ST_RTI;
			ST_SELIR: next_state = tms_s ? ST_TLR   : ST_CAPIR;
			ST_CAPIR: next_state = tms_s ? ST_EX1IR : ST_SHIR;
			ST_SHIR:  next_state = tms_s ? ST_EX1IR : ST_SHIR;
			ST_EX1IR: next_state = tms_s ? ST_UPIR  : ST_PSIR;
			ST_PSIR:  next_state = tms_s ? ST_EX2IR : ST_PSIR;
			ST_EX2IR: next_state = tms_s ? ST_UPIR  : ST_SHIR;
			ST_UPIR:  next_state = tms_s ? ST_SELDR : ST_RTI;
			default:  next_state = ST_TLR;
		endcase
	end

	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state <= ST_TLR;
		end else if (tck_rise) begin
			state <= next_state;
		end
	end

	// ==========================================================
	// instruction register
	reg [`JTDR_IR_W-1:0] ir;
	reg [`JTDR_IR_W-1:0] ir_sh;

	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ir <= `JTDR_OP_IDENT;
			ir_sh <= `JTDR_IR_CAPTURE;
		end else if (tck_rise) begin
			case (state)
				ST_TLR:   ir <= `JTDR_OP_IDENT;
				ST_CAPIR: ir_sh <= `JTDR_IR_CAPTURE;
				ST_SHIR:  ir_sh <= {tdi_s, ir_sh[`JTDR_IR_W-1:1]};
				ST_UPIR:  ir <= ir_sh;
				default:  ir <= ir;
			endcase
		end
	end

	wire sel_ident = (ir == `JTDR_OP_IDENT);
	wire sel_dom   = (ir == `JTDR_OP_DOM_RESET);
	wire sel_bs    = (ir == `JTDR_OP_SAMPLE) || (ir == `JTDR_OP_EXTEST);

	// ==========================================================
	// identification and domain-reset data registers
	// one shared shift register; its active length follows the instruction
	reg [`JTDR_ID_W-1:0]  dr_sh;
	reg [`JTDR_DOM_W-1:0] dom_hold;

	// identity word; while flash is held in reset the tester may not trust it
	wire [`JTDR_ID_W-1:0] id_word = {ID_REV, ID_PROD, ID_MAKER, 1'b1};

	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			dr_sh <= {`JTDR_ID_W{1'b0}};
			dom_hold <= `JTDR_DOM_RST_VAL;
		end else if (tck_rise) begin
			case (state)
				ST_TLR: begin
					dom_hold <= `JTDR_DOM_RST_VAL;
				end
				ST_CAPDR: begin
					if (sel_ident) begin
						dr_sh <= id_word;
					end else if (sel_dom) begin
						dr_sh <= {27'h0, dom_hold};
					end else begin
						dr_sh <= {`JTDR_ID_W{1'b0}};
					end
				end
				ST_SHDR: begin
					if (sel_ident) begin
						dr_sh <= {tdi_s, dr_sh[`JTDR_ID_W-1:1]};
					end else if (sel_dom) begin
						dr_sh[`JTDR_DOM_W-1:0] <= {tdi_s, dr_sh[`JTDR_DOM_W-1:1]};
					end else begin
						dr_sh[0] <= tdi_s;
					end
				end
				ST_UPDR: begin
					// whole word taken as shifted; short shifts leave stale bits in
					if (sel_dom) begin
						dom_hold <= dr_sh[`JTDR_DOM_W-1:0];
					end
				end
				default: begin
					dom_hold <= dom_hold;
				end
			endcase
		end
	end

	// domain holds; bits 1 and 2 are stored but drive nothing
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			core_rst_hold_o <= 1'b0;
			bus_rst_hold_o <= 1'b0;
			debug_rst_hold_o <= 1'b0;
		end else begin
			core_rst_hold_o <= dom_hold[`JTDR_DOM_CORE];
			bus_rst_hold_o <= dom_hold[`JTDR_DOM_BUS];
			debug_rst_hold_o <= dom_hold[`JTDR_DOM_DEBUG];
		end
	end

	// ==========================================================
	// boundary-scan chain
	wire bs_tdo;

	jtdr_bscan #(
		.NPINS (NPINS)
	) u_bscan (
		.mclk_i     (mclk_i),
		.rst_n_i    (rst_n_i),
		.cap_i      (tck_rise && sel_bs && (state == ST_CAPDR)),
		.shift_i    (tck_rise && sel_bs && (state == ST_SHDR)),
		.upd_i      (tck_rise && sel_bs && (state == ST_UPDR)),
		.extest_i   (ir == `JTDR_OP_EXTEST),
		.tdi_i      (tdi_s),
		.pin_in_i   (pin_in_i),
		.core_out_i (core_out_i),
		.core_oe_i  (core_oe_i),
		.tdo_o      (bs_tdo),
		.pin_out_o  (pin_out_o),
		.pin_oe_o   (pin_oe_o),
		.core_in_o  (core_in_o)
	);

	// ==========================================================
	// test data out, changed on falling tck so the tester samples it stable
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			tdo_o <= 1'b0;
			tdo_oe_o <= 1'b0;
		end else if (tck_fall) begin
			tdo_oe_o <= (state == ST_SHDR) || (state == ST_SHIR);
			if (state == ST_SHIR) begin
				tdo_o <= ir_sh[0];
			end else if (sel_bs) begin
				tdo_o <= bs_tdo;
			end else begin
				tdo_o <= dr_sh[0];
			end
		end
	end

	// ==========================================================
	// service bus slave decode, one register stage
	wire [3:0] slv = sab_addr_i[`JTDR_SAB_SLV_HI:`JTDR_SAB_SLV_LO];

	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			sab_sel_debug_o <= 1'b0;
			sab_sel_sysbus_o <= 1'b0;
			sab_sel_msu_o <= 1'b0;
			sab_unmapped_o <= 1'b0;
			sab_local_addr_o <= 32'h0;
		end else begin
			sab_local_addr_o <= sab_addr_i[31:0];
			sab_sel_debug_o <= sab_req_i && (slv == `JTDR_SLV_DEBUG);
			sab_sel_sysbus_o <= sab_req_i && ((slv == `JTDR_SLV_SYSBUS) ||
			                                  (slv == `JTDR_SLV_SYSALIAS));
			sab_sel_msu_o <= sab_req_i && (slv == `JTDR_SLV_MSU);
			sab_unmapped_o <= sab_req_i && (slv != `JTDR_SLV_DEBUG) &&
			                  (slv != `JTDR_SLV_SYSBUS) && (slv != `JTDR_SLV_SYSALIAS) &&
			                  (slv != `JTDR_SLV_MSU);
		end
	end

endmodule

// *** pkg/jtdr_consts.vh ***
// jtdr_consts.vh: constants for the test-port data registers and the service bus decoder.
// assumes: included by bare name from the design files under logic/.
//
// Behaviour
// - test-logic reset loads the identification instruction, selecting the 32-bit id register
// - id bits 31..28 hold a 4-bit silicon revision, incremented per revision
// - id bits 27..12 hold a 16-bit product code per memory and package variant
// - id bits 11..1 hold an 11-bit maker code; bit 0 is always one
// - id value is undefined while the flash controller is held in reset
// - domain-reset instruction selects one bit per domain; one holds reset until zero
// - 5-bit domain register: bit0 core, bit3 bus domain, bit4 debug; bits 1,2 inert
// - boundary chain drives and observes pin levels, output values, enables and inputs
// - service bus address is 36 bits: top 4 pick slave, low 32 inside slave
// - slave 1 selects debug registers; slave 4 selects system bus memory space
// - slave 5 aliases slave 4 system bus memory space for compatibility
// - slave 6 selects memory service unit; slave 0 and the rest map nothing
`ifndef JTDR_CONSTS_VH
`define JTDR_CONSTS_VH

// ==========================================================
// instruction register
`define JTDR_IR_W          5
`define JTDR_IR_CAPTURE    5'h01
`define JTDR_OP_IDENT      5'h01
`define JTDR_OP_SAMPLE     5'h02
`define JTDR_OP_EXTEST     5'h03
`define JTDR_OP_DOM_RESET  5'h0c
`define JTDR_OP_BYPASS     5'h1f

// ==========================================================
// identification register layout
`define JTDR_ID_W          32
`define JTDR_ID_REV_HI     31
`define JTDR_ID_REV_LO     28
`define JTDR_ID_PROD_HI    27
`define JTDR_ID_PROD_LO    12
`define JTDR_ID_MAKER_HI   11
`define JTDR_ID_MAKER_LO   1
`define JTDR_ID_FIXED_BIT  0

// ==========================================================
// domain reset register layout and reset value
`define JTDR_DOM_W         5
`define JTDR_DOM_CORE      0
`define JTDR_DOM_BUS       3
`define JTDR_DOM_DEBUG     4
`define JTDR_DOM_RST_VAL   5'h00

// ==========================================================
// service access bus decode
`define JTDR_SAB_AW        36
`define JTDR_SAB_SLV_HI    35
`define JTDR_SAB_SLV_LO    32
`define JTDR_SLV_NONE      4'h0
`define JTDR_SLV_DEBUG     4'h1
`define JTDR_SLV_SYSBUS    4'h4
`define JTDR_SLV_SYSALIAS  4'h5
`define JTDR_SLV_MSU       4'h6

`endif

// *** logic/jtdr_bscan.v ***
// jtdr_bscan.v: boundary-scan chain, three cells per pin (input, output value, output enable).
// assumes: strobes come from the tap logic in mclk_i domain, one cycle each.
`timescale 1ns/100ps
`include "jtdr_consts.vh"

module jtdr_bscan #(
	parameter NPINS = 8
) (
	input  wire             mclk_i,
	input  wire             rst_n_i,
	input  wire             cap_i,
	input  wire             shift_i,
	input  wire             upd_i,
	input  wire             extest_i,
	input  wire             tdi_i,
	input  wire [NPINS-1:0] pin_in_i,
	input  wire [NPINS-1:0] core_out_i,
	input  wire [NPINS-1:0] core_oe_i,
	output wire             tdo_o,
	output reg  [NPINS-1:0] pin_out_o,
	output reg  [NPINS-1:0] pin_oe_o,
	output reg  [NPINS-1:0] core_in_o
);

	reg  [3*NPINS-1:0] chain;
	reg  [3*NPINS-1:0] upd_reg;
	reg  [NPINS-1:0]   pin_m;
	reg  [NPINS-1:0]   pin_s;
	wire [3*NPINS-1:0] cap_word;
	wire [NPINS-1:0]   next_pin_out;
	wire [NPINS-1:0]   next_pin_oe;
	wire [NPINS-1:0]   next_core_in;

	assign tdo_o = chain[0];

	// ==========================================================
	// pad synchronisers
	// pads are asynchronous to mclk_i; two flops before anything reads them
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pin_m <= {NPINS{1'b0}};
			pin_s <= {NPINS{1'b0}};
		end else begin
			pin_m <= pin_in_i;
			pin_s <= pin_m;
		end
	end

	// ==========================================================
	// per-pin cells: capture word and extest muxes
	genvar g;
	generate
		for (g = 0; g < NPINS; g = g + 1) begin : g_cell
			assign cap_word[3*g+2:3*g] = {core_oe_i[g], core_out_i[g], pin_s[g]};
			assign next_pin_out[g] = extest_i ? upd_reg[3*g+1] : core_out_i[g];
			assign next_pin_oe[g] = extest_i ? upd_reg[3*g+2] : core_oe_i[g];
			assign next_core_in[g] = extest_i ? upd_reg[3*g] : pin_s[g];
		end
	endgenerate

	// ==========================================================
	// shift path, lsb toward tdo
	// one process for the whole chain, so no bit has two drivers
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			chain <= {3*NPINS{1'b0}};
			upd_reg <= {3*NPINS{1'b0}};
		end else if (cap_i) begin
			chain <= cap_word;
		end else if (shift_i) begin
			chain <= {tdi_i, chain[3*NPINS-1:1]};
		end else if (upd_i) begin
			upd_reg <= chain;
		end
	end

	// in extest the chain owns the pins and the core sees the update cells
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pin_out_o <= {NPINS{1'b0}};
			pin_oe_o <= {NPINS{1'b0}};
			core_in_o <= {NPINS{1'b0}};
		end else begin
			pin_out_o <= next_pin_out;
			pin_oe_o <= next_pin_oe;
			core_in_o <= next_core_in;
		end
	end

endmodule

// *** sim/jtdr_chk.sv ***
// jtdr_chk.sv: port assertions for the test-port block.
// assumes: bound to jtdr_top; tck_i far slower than mclk_i.
`timescale 1ns/100ps
module jtdr_chk (
	input wire        mclk_i,
	input wire        rst_n_i,
	input wire        tck_i,
	input wire        tdo_o,
	input wire        core_rst_hold_o,
	input wire        bus_rst_hold_o,
	input wire        debug_rst_hold_o,
	input wire        sab_req_i,
	input wire [35:0] sab_addr_i,
	input wire        sab_sel_debug_o,
	input wire        sab_sel_sysbus_o,
	input wire        sab_sel_msu_o,
	input wire        sab_unmapped_o,
	input wire [31:0] sab_local_addr_o
);
	// ====
	// decode helpers
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	wire [3:0] slv = sab_addr_i[35:32];
	wire [3:0] sel = {sab_sel_debug_o, sab_sel_sysbus_o, sab_sel_msu_o, sab_unmapped_o};
	wire [2:0] hold = {core_rst_hold_o, bus_rst_hold_o, debug_rst_hold_o};
	// seven low samples: any update from the last rise or fall has landed
	sequence s_tck_quiet;
		!tck_i [*7];
	endsequence
	// ====
	// properties
	property p_dbg; sab_req_i && slv == 4'h1 |=> sel == 4'h8; endproperty
	property p_sys; sab_req_i && (slv == 4'h4 || slv == 4'h5) |=> sel == 4'h4; endproperty
	property p_msu; sab_req_i && slv == 4'h6 |=> sel == 4'h2; endproperty
	property p_unm; sab_req_i && !(slv inside {1, 4, 5, 6}) |=> sel == 4'h1; endproperty
	property p_idle; !sab_req_i |=> sel == 4'h0; endproperty
	property p_loc; sab_req_i |=> sab_local_addr_o == $past(sab_addr_i[31:0]); endproperty
	property p_hold; s_tck_quiet |-> $stable(hold); endproperty
	property p_tdo; s_tck_quiet |-> $stable(tdo_o); endproperty
	a_dbg: assert property (p_dbg) else $error("debug slave select wrong");
	a_sys: assert property (p_sys) else $error("system bus select wrong");
	a_msu: assert property (p_msu) else $error("memory service select wrong");
	a_unm: assert property (p_unm) else $error("unmapped flag wrong");
	a_idle: assert property (p_idle) else $error("select without request");
	a_loc: assert property (p_loc) else $error("local address wrong");
	a_hold: assert property (p_hold) else $error("hold moved with tck idle");
	a_tdo: assert property (p_tdo) else $error("tdo moved with tck idle");
endmodule
bind jtdr_top jtdr_chk u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .tck_i(tck_i),
	.tdo_o(tdo_o), .core_rst_hold_o(core_rst_hold_o), .bus_rst_hold_o(bus_rst_hold_o),
	.debug_rst_hold_o(debug_rst_hold_o), .sab_req_i(sab_req_i), .sab_addr_i(sab_addr_i),
	.sab_sel_debug_o(sab_sel_debug_o), .sab_sel_sysbus_o(sab_sel_sysbus_o),
	.sab_sel_msu_o(sab_sel_msu_o), .sab_unmapped_o(sab_unmapped_o),
	.sab_local_addr_o(sab_local_addr_o));

// *** sim/jtdr_tester.sv ***
// jtdr_tester.sv: external tester model driving the test port.
// assumes: mclk_i is the bench clock; one tck bit is 8 mclk (400 ns).
`timescale 1ns/100ps
module jtdr_tester (
	input  wire mclk_i,
	input  wire tdo_i,
	output reg  tck_o,
	output reg  tms_o,
	output reg  tdi_o
);
	// ====
	// idle: tck parked low, data lines at pull-up level
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
	end
	// lines move on the fall, tdo taken just before the rise
	task bit_go(input m, input d, output o);
		begin
			tms_o <= m;
			tdi_o <= d;
			repeat (4) @(posedge mclk_i);
			o = tdo_i;
			tck_o <= 1'b1;
			repeat (4) @(posedge mclk_i);
			tck_o <= 1'b0;
		end
	endtask
	// tms walk, lsb first
	task walk(input [7:0] seq, input integer n);
		reg     o;
		integer i;
		begin
			for (i = 0; i < n; i++) bit_go(seq[i], 1'b1, o);
		end
	endtask
	// full shift, then update and back to idle
	task shift(input [31:0] din, input integer n, output [31:0] dout);
		reg     o;
		integer i;
		begin
			dout = 32'h0;
			for (i = 0; i < n; i++) begin
				bit_go(i == n - 1, din[i], o);
				dout[i] = o;
			end
			walk(8'h01, 2);
		end
	endtask
endmodule

// *** sim/tb_top.sv ***
// tb_top.sv: self-checking bench for the test-port block.
// assumes: design files and jtdr_consts.vh on the include path.
`timescale 1ns/100ps
module tb_top;
	localparam [31:0] ID = {4'h3, 16'hbeef, 11'h155, 1'b1}; // arbitrary values
	reg         mclk, rst_n, sab_req;
	reg  [35:0] sab_addr, a;
	reg  [7:0]  pin_in, core_out, core_oe;
	reg  [31:0] d;
	reg  [23:0] e, x;
	wire [7:0]  pin_out, pin_oe, core_in;
	wire        tdo_oe;
	reg  [35:0] exp_q[$];
	wire        tck, tms, tdi, tdo, core_h, bus_h, dbg_h;
	wire [3:0]  sel;
	wire [31:0] loc;
	integer     fail_count = 0, checks_done = 0, seed = 32'h9ec3, i;

	jtdr_top #(.NPINS(8), .ID_REV(4'h3), .ID_PROD(16'hbeef), .ID_MAKER(11'h155)) dut (
		.mclk_i(mclk), .rst_n_i(rst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
		.tdo_o(tdo), .tdo_oe_o(tdo_oe), .pin_in_i(pin_in), .core_out_i(core_out),
		.core_oe_i(core_oe), .pin_out_o(pin_out), .pin_oe_o(pin_oe), .core_in_o(core_in),
		.core_rst_hold_o(core_h), .bus_rst_hold_o(bus_h), .debug_rst_hold_o(dbg_h),
		.sab_req_i(sab_req), .sab_addr_i(sab_addr), .sab_sel_debug_o(sel[3]),
		.sab_sel_sysbus_o(sel[2]), .sab_sel_msu_o(sel[1]), .sab_unmapped_o(sel[0]),
		.sab_local_addr_o(loc));
	jtdr_tester u_tst (.mclk_i(mclk), .tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

	// ====
	// checking and ending
	task cmp(input [35:0] ex, input [35:0] g);
		begin
			checks_done++;
			if (g !== ex) begin
				fail_count++;
				$display("unexpected at %0t: exp %h got %h", $time, ex, g);
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", checks_done, fail_count);
			if (fail_count == 0 && checks_done > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// instruction load, capture pattern checked on the way
	task ir(input [4:0] op);
		begin
			u_tst.walk(8'h03, 4);
			u_tst.shift({27'h0, op}, 5, d);
			cmp(5'h01, d[4:0]);
		end
	endtask
	// outputs launched by the update edge are read one mclk later
	task dr(input [31:0] v, input integer n);
		begin
			u_tst.walk(8'h01, 3);
			u_tst.shift(v, n, d);
			@(posedge mclk);
			cmp(36'h0, tdo_oe);
		end
	endtask
	// pin side of the chain, packed like the cells
	task pins(input [23:0] ex);
		begin
			for (i = 0; i < 8; i++) x[3*i +: 3] = {pin_oe[i], pin_out[i], core_in[i]};
			cmp(ex, x);
		end
	endtask

	// ====
	// clock, watchdog, service bus monitor
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		#2_000_000;
		fail_count++;
		tally_and_finish;
	end
	always @(posedge mclk)
		if (|sel) begin
			if (exp_q.size() == 0)
				cmp(36'h0, {sel, loc});
			else
				cmp(exp_q.pop_front(), {sel, loc});
		end

	// ====
	// main sequence
	initial begin
		rst_n = 1'b0;
		sab_req = 1'b0;
		sab_addr = 36'h0;
		pin_in <= $random(seed);
		core_out <= $random(seed);
		core_oe <= $random(seed);
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		// identity straight after test-logic reset, no instruction loaded
		u_tst.walk(8'h1f, 6);
		dr(32'h0, 32);
		cmp(ID, d);
		// domain holds: set, inert bits only, then cleared by test-logic reset
		ir(5'h0c);
		dr(32'h1f, 5);
		cmp(3'h7, {core_h, bus_h, dbg_h});
		dr(32'h06, 5);
		cmp(5'h1f, d[4:0]);
		cmp(3'h0, {core_h, bus_h, dbg_h});
		dr(32'h1f, 5);
		u_tst.walk(8'h1f, 6);
		cmp(3'h0, {core_h, bus_h, dbg_h});
		// boundary sample: input, output value, enable per pin
		ir(5'h02);
		dr(32'h0, 24);
		for (i = 0; i < 8; i++) e[3*i +: 3] = {core_oe[i], core_out[i], pin_in[i]};
		cmp(e, d[23:0]);
		pins(e);
		// extest: update cells own pins and core input; capture is unchanged
		ir(5'h03);
		a = $random(seed);
		dr(a[31:0], 24);
		cmp(e, d[23:0]);
		pins(a[23:0]);
		// test-logic reset hands the pins back to the core
		u_tst.walk(8'h1f, 6);
		pins(e);
		// every slave number back to back with random local addresses
		for (i = 0; i < 16; i++) begin
			@(posedge mclk);
			a = {i[3:0], $random(seed)};
			sab_req <= 1'b1;
			sab_addr <= a;
			exp_q.push_back({(i == 1), (i == 4 || i == 5), (i == 6),
				!(i == 1 || i == 4 || i == 5 || i == 6), a[31:0]});
		end
		@(posedge mclk);
		sab_req <= 1'b0;
		repeat (3) @(posedge mclk);
		cmp(36'h0, exp_q.size());
		tally_and_finish;
	end
endmodule
